/* File: hdl/cw_access_regs.vh */
`ifndef CW_ACCESS_REGS_VH
`define CW_ACCESS_REGS_VH

`define CW_ADDR_W          8
`define OFS_LAYER_ONE      8'h00
`define OFS_LINE_RATE      8'h0C
`define OFS_WORD_SEL       8'h40
`define OFS_RX_WORD        8'h44
`define OFS_TX_WORD        8'h48

`define CW_ENTRIES         256
`define CW_SECTIONS        4'hC
`define CW_TAB_DEPTH       4096

`define SEL_RX_X_LSB       0
`define SEL_RX_SEQ_LSB     8
`define SEL_RX_WPOS_BIT    12
`define SEL_TX_X_LSB       16
`define SEL_TX_SEQ_LSB     24
`define SEL_TX_WPOS_BIT    28
`define SEL_TX_INSERT_BIT  31

`define L1_INSERT_EN_BIT   0
`define RATE_FIELD_LSB     0
`define RATE_ACTUAL_LSB    8

`define RST_INSERT_EN      1'h0
`define RST_RATE_FIELD     6'h01
`define RST_SEL_X          8'h00
`define RST_SEL_SEQ        4'h0
`define NEGO_FOLLOW_REG    6'h00

`endif

/* File: hdl/hyperframe_control_word_access.v */
`timescale 1ns/1ps
`default_nettype none
`include "cw_access_regs.vh"

// Function
// - 64-bit path: index written, seq and wpos zero, first section readable next cycle.
// - 64-bit path: wpos 1 selects second section, readable next cycle.
// - 64-bit path: seq 1, wpos 0 selects third section next cycle.
// - 64-bit path: seq 1, wpos 1 selects fourth section.
// - 64-bit path: seq 2, wpos 0 selects fifth section next cycle.
// - 64-bit path at 10.1376 Gbps a further step exposes sixth section.
// - At 24.33024 Gbps receive sections continue the same wpos and seq alternation.
// - Transmit table holds 256 entries, each with contents and own enable bit.
// - Frame word replaced only when entry enabled and global insert enable set.
// - 32-bit path: transmit seq zero selects first section written via data register.
// - 32-bit path: transmit seq 1 to 4 select second to fifth sections.
// - 64-bit path: transmit sections follow the receive seq and wpos pattern.
// - Per-entry insert bit in index register enables that entry in the frame.
// - Global insert enable is master; set means every enabled entry is inserted in sections below twelve.
// - With negotiation enabled by parameter, rate may change via input or register.
// - Nonzero negotiation rate overrides register field; all zeros follows the field.
// - First control byte sits in bits 31 to 24, later bytes in lower lanes.
// - 32-bit path: receive seq steps from zero upward to pick sections.
module hyperframe_control_word_access #(
	parameter DATA_PATH_64 = 1,
	parameter AUTONEG_EN   = 1
) (
	input  wire                   mclk,
	input  wire                   nrst,
	input  wire [`CW_ADDR_W-1:0]  addr,
	input  wire [31:0]            wr_data,
	input  wire                   wr_en,
	input  wire                   rd_en,
	output reg  [31:0]            rd_data_ff,
	input  wire                   rx_cw_valid,
	input  wire [7:0]             rx_cw_index,
	input  wire [3:0]             rx_cw_sect,
	input  wire [31:0]            rx_cw_data,
	input  wire                   tx_cw_req,
	input  wire [7:0]             tx_cw_index,
	input  wire [3:0]             tx_cw_sect,
	input  wire [31:0]            tx_cw_orig,
	output reg                    tx_cw_valid_ff,
	output reg  [31:0]            tx_cw_data_ff,
	input  wire [5:0]             nego_rate_in,
	output reg  [5:0]             line_rate_ff
);

	reg  [7:0]   rx_x_ff;
	reg  [3:0]   rx_seq_ff;
	reg          rx_wpos_ff;
	reg  [7:0]   tx_x_ff;
	reg  [3:0]   tx_seq_ff;
	reg          tx_wpos_ff;
	reg          insert_en_ff;
	reg  [5:0]   rate_field_ff;
	reg  [`CW_ENTRIES-1:0] entry_en_ff;
	reg  [31:0]  rx_tab_ff [0:`CW_TAB_DEPTH-1];
	reg  [31:0]  tx_tab_ff [0:`CW_TAB_DEPTH-1];
	reg  [31:0]  nxt_rd_data;
	reg  [5:0]   nxt_line_rate;

	wire         wr_sel;
	wire         wr_tx_word;
	wire         wr_l1;
	wire         wr_rate;
	wire [3:0]   rx_sect;
	wire [3:0]   tx_sect;
	wire [11:0]  rx_ptr;
	wire [11:0]  tx_ptr;
	wire [11:0]  link_rx_ptr;
	wire [11:0]  link_tx_ptr;
	wire [7:0]   new_tx_x;
	wire [7:0]   new_rx_x;
	wire [3:0]   new_rx_seq;
	wire         new_rx_wpos;
	wire [3:0]   new_tx_seq;
	wire         new_tx_wpos;
	wire         new_insert;
	wire         rx_sect_ok;
	wire         tx_sect_ok;
	wire         link_rx_ok;
	wire         link_tx_ok;
	wire         rx_store;
	wire         tx_store;
	wire         insert_hit;
	wire [31:0]  sel_view;
	wire [31:0]  l1_view;
	wire [31:0]  rate_view;
	reg  [31:0]  nxt_tx_data;
	reg          nxt_tx_valid;
	integer      i;
	integer      j;

	// A 64-bit path carries two sections per sequence step, so the word
	// position picks the half; a 32-bit path uses the sequence alone.
	function [3:0] sect_of;
		input [3:0] seq;
		input       wpos;
		begin
			if (DATA_PATH_64 != 0)
				sect_of = {seq[2:0], wpos};
			else
				sect_of = seq;
		end
	endfunction

	assign wr_sel     = wr_en && (addr == `OFS_WORD_SEL);
	assign wr_tx_word = wr_en && (addr == `OFS_TX_WORD);
	assign wr_l1      = wr_en && (addr == `OFS_LAYER_ONE);
	assign wr_rate    = wr_en && (addr == `OFS_LINE_RATE);
	assign new_tx_x   = wr_data[`SEL_TX_X_LSB+7:`SEL_TX_X_LSB];
	assign new_rx_x    = wr_data[`SEL_RX_X_LSB+7:`SEL_RX_X_LSB];
	assign new_rx_seq  = wr_data[`SEL_RX_SEQ_LSB+3:`SEL_RX_SEQ_LSB];
	assign new_rx_wpos = wr_data[`SEL_RX_WPOS_BIT];
	assign new_tx_seq  = wr_data[`SEL_TX_SEQ_LSB+3:`SEL_TX_SEQ_LSB];
	assign new_tx_wpos = wr_data[`SEL_TX_WPOS_BIT];
	assign new_insert  = wr_data[`SEL_TX_INSERT_BIT];

	assign rx_sect = sect_of(rx_seq_ff, rx_wpos_ff);
	assign tx_sect = sect_of(tx_seq_ff, tx_wpos_ff);

	// Entries are addressed by control word number then section, so any
	// sequence step up to the twelfth section is reachable.
	assign rx_ptr      = {rx_x_ff, rx_sect};
	assign tx_ptr      = {tx_x_ff, tx_sect};
	assign link_rx_ptr = {rx_cw_index, rx_cw_sect};
	assign link_tx_ptr = {tx_cw_index, tx_cw_sect};

	// Sections past the last one the widest rate uses are never stored;
	// they are dropped on write and read back as zero.
	assign rx_sect_ok = (rx_sect < `CW_SECTIONS);
	assign tx_sect_ok = (tx_sect < `CW_SECTIONS);
	assign link_rx_ok = (rx_cw_sect < `CW_SECTIONS);
	assign link_tx_ok = (tx_cw_sect < `CW_SECTIONS);
	assign rx_store   = rx_cw_valid && link_rx_ok;
	assign tx_store   = wr_tx_word && tx_sect_ok;
	assign insert_hit = insert_en_ff && entry_en_ff[tx_cw_index] && link_tx_ok;

	// Word select readback; bits 30:29 and 15:13 are unused and read zero.
	assign sel_view = {
		entry_en_ff[tx_x_ff],
		2'b00,
		tx_wpos_ff,
		tx_seq_ff,
		tx_x_ff,
		3'b000,
		rx_wpos_ff,
		rx_seq_ff,
		rx_x_ff
	};

	assign l1_view   = {31'h00000000, insert_en_ff};
	assign rate_view = {
		18'h00000,
		line_rate_ff,
		2'b00,
		rate_field_ff
	};

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			rx_x_ff    <= `RST_SEL_X;
			rx_seq_ff  <= `RST_SEL_SEQ;
			rx_wpos_ff <= 1'b0;
		end
		else if (wr_sel)
		begin
			rx_x_ff    <= new_rx_x;
			rx_seq_ff  <= new_rx_seq;
			rx_wpos_ff <= new_rx_wpos;
		end
	end

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			tx_x_ff    <= `RST_SEL_X;
			tx_seq_ff  <= `RST_SEL_SEQ;
			tx_wpos_ff <= 1'b0;
		end
		else if (wr_sel)
		begin
			tx_x_ff    <= new_tx_x;
			tx_seq_ff  <= new_tx_seq;
			tx_wpos_ff <= new_tx_wpos;
		end
	end

	// The insert bit travels with the index write, so it lands on the entry
	// named in that same write.
	genvar g;
	generate
		for (g = 0; g < `CW_ENTRIES; g = g + 1)
		begin : g_entry_en
			localparam [7:0] ENTRY = g;
			always @(posedge mclk)
			begin
				if (!nrst)
					entry_en_ff[g] <= 1'b0;
				else if (wr_sel && (new_tx_x == ENTRY))
					entry_en_ff[g] <= new_insert;
			end
		end
	endgenerate

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			insert_en_ff  <= `RST_INSERT_EN;
			rate_field_ff <= `RST_RATE_FIELD;
		end
		else
		begin
			if (wr_l1)
				insert_en_ff <= wr_data[`L1_INSERT_EN_BIT];
			if (wr_rate)
				rate_field_ff <= wr_data[`RATE_FIELD_LSB+5:`RATE_FIELD_LSB];
		end
	end

	// Clearing the whole table on reset costs a wide reset fan-out, but it
	// keeps every read defined before the link has delivered a word.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (i = 0; i < `CW_TAB_DEPTH; i = i + 1)
				rx_tab_ff[i] <= 32'h00000000;
		end
		else if (rx_store)
			rx_tab_ff[link_rx_ptr] <= rx_cw_data;
	end

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (j = 0; j < `CW_TAB_DEPTH; j = j + 1)
				tx_tab_ff[j] <= 32'h00000000;
		end
		else if (tx_store)
			tx_tab_ff[tx_ptr] <= wr_data;
	end

	always @*
	begin
		nxt_rd_data = 32'h00000000;
		if (rd_en)
		begin
			case (addr)
				`OFS_LAYER_ONE:
				begin
					nxt_rd_data = l1_view;
				end
				`OFS_LINE_RATE:
				begin
					nxt_rd_data = rate_view;
				end
				`OFS_WORD_SEL:
				begin
					nxt_rd_data = sel_view;
				end
				`OFS_RX_WORD:
				begin
					if (rx_sect_ok)
						nxt_rd_data = rx_tab_ff[rx_ptr];
				end
				`OFS_TX_WORD:
				begin
					if (tx_sect_ok)
						nxt_rd_data = tx_tab_ff[tx_ptr];
				end
				default:
				begin
					nxt_rd_data = 32'h00000000;
				end
			endcase
		end
	end

	// Read data stand for one cycle only and return to zero after it.
	always @(posedge mclk)
	begin
		if (!nrst)
			rd_data_ff <= 32'h00000000;
		else
			rd_data_ff <= nxt_rd_data;
	end

	// The framer's own word passes through unless the master enable is set, its entry is armed and its section is below twelve, so a
	// half-loaded table never leaks out while the master enable is off.
	always @*
	begin
		nxt_tx_valid = tx_cw_req;
		nxt_tx_data  = tx_cw_data_ff;
		if (tx_cw_req)
		begin
			if (insert_hit)
				nxt_tx_data = tx_tab_ff[link_tx_ptr];
			else
				nxt_tx_data = tx_cw_orig;
		end
	end

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			tx_cw_valid_ff <= 1'b0;
			tx_cw_data_ff  <= 32'h00000000;
		end
		else
		begin
			tx_cw_valid_ff <= nxt_tx_valid;
			tx_cw_data_ff  <= nxt_tx_data;
		end
	end

	// The negotiation input wins whenever it carries a code; a zero code
	// hands control back to software.
	always @*
	begin
		nxt_line_rate = rate_field_ff;
		if ((AUTONEG_EN != 0) && (nego_rate_in != `NEGO_FOLLOW_REG))
			nxt_line_rate = nego_rate_in;
	end

	always @(posedge mclk)
	begin
		if (!nrst)
			line_rate_ff <= `RST_RATE_FIELD;
		else
			line_rate_ff <= nxt_line_rate;
	end

endmodule
`default_nettype wire

/* File: verif/hyperframe_control_word_access_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cw_access_regs.vh"
module hyperframe_control_word_access_properties (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rd_data_ff,
	input wire logic        rx_cw_valid,
	input wire logic [7:0]  rx_cw_index,
	input wire logic [3:0]  rx_cw_sect,
	input wire logic [31:0] rx_cw_data,
	input wire logic        tx_cw_req,
	input wire logic [7:0]  tx_cw_index,
	input wire logic [3:0]  tx_cw_sect,
	input wire logic [31:0] tx_cw_orig,
	input wire logic        tx_cw_valid_ff,
	input wire logic [31:0] tx_cw_data_ff,
	input wire logic [5:0]  nego_rate_in,
	input wire logic [5:0]  line_rate_ff
);
	logic [31:0] sel_ff;
	logic        glob_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Shadows of software state, so the checker needs no view inside the block.
	always_ff @(posedge mclk)
		sel_ff <= !nrst ? 32'h0 : (wr_en && addr == `OFS_WORD_SEL) ? wr_data : sel_ff;
	always_ff @(posedge mclk)
		glob_ff <= !nrst ? 1'h0 : (wr_en && addr == `OFS_LAYER_ONE) ? wr_data[0] : glob_ff;
	AST_RD_IDLE: assert property (!rd_en |=> rd_data_ff == 32'h0)
		else $error("read data not zero outside read slot");
	AST_RD_SEL: assert property (rd_en && addr == `OFS_WORD_SEL |=>
		(rd_data_ff & 32'h9FFF_1FFF) == ($past(sel_ff) & 32'h9FFF_1FFF))
		else $error("word select reads back wrong");
	AST_TX_VALID: assert property (tx_cw_req |=> tx_cw_valid_ff)
		else $error("no valid after section request");
	AST_TX_QUIET: assert property (!tx_cw_req |=> !tx_cw_valid_ff && $stable(tx_cw_data_ff))
		else $error("tx port moved without request");
	AST_TX_MASTER: assert property (tx_cw_req && !glob_ff |=> tx_cw_data_ff == $past(tx_cw_orig))
		else $error("inserted while master enable off");
	AST_TX_SECT: assert property (tx_cw_req && tx_cw_sect >= 4'hC |=> tx_cw_data_ff == $past(tx_cw_orig))
		else $error("section beyond table inserted");
	AST_RATE_NEGO: assert property (nego_rate_in != 6'h00 |=> line_rate_ff == $past(nego_rate_in))
		else $error("negotiation rate not followed");
	AST_RATE_REG: assert property (wr_en && addr == `OFS_LINE_RATE && nego_rate_in == 6'h00
		##1 !wr_en && nego_rate_in == 6'h00 |=> line_rate_ff == 6'($past(wr_data, 2)))
		else $error("rate field not followed");
	cover property (tx_cw_req && glob_ff);
	cover property (rd_en && addr == `OFS_RX_WORD);
	cover property (nego_rate_in != 6'h00);
endmodule
bind hyperframe_control_word_access hyperframe_control_word_access_properties i_props (
	.mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data_ff(rd_data_ff), .rx_cw_valid(rx_cw_valid), .rx_cw_index(rx_cw_index),
	.rx_cw_sect(rx_cw_sect), .rx_cw_data(rx_cw_data), .tx_cw_req(tx_cw_req),
	.tx_cw_index(tx_cw_index), .tx_cw_sect(tx_cw_sect), .tx_cw_orig(tx_cw_orig),
	.tx_cw_valid_ff(tx_cw_valid_ff), .tx_cw_data_ff(tx_cw_data_ff),
	.nego_rate_in(nego_rate_in), .line_rate_ff(line_rate_ff));
`default_nettype wire

/* File: verif/hyperframe_control_word_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cw_access_regs.vh"
module hyperframe_control_word_access_tb;
	logic        mclk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
	logic        rx_cw_valid = 1'h0, tx_cw_req = 1'h0;
	logic [7:0]  addr = 8'h00, rx_cw_index = 8'h00, tx_cw_index = 8'h50;
	logic [3:0]  rx_cw_sect = 4'h0, tx_cw_sect = 4'h0;
	logic [31:0] wr_data = 32'h0, rx_cw_data = 32'h0, tx_cw_orig = 32'h0;
	logic [5:0]  nego_rate_in = 6'h00;
	wire  [31:0] rd_data_ff, tx_cw_data_ff;
	wire  [5:0]  line_rate_ff;
	wire         tx_cw_valid_ff;
	int          bad_count = 0, checked = 0;
	hyperframe_control_word_access i_dut (
		.mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data_ff(rd_data_ff), .rx_cw_valid(rx_cw_valid), .rx_cw_index(rx_cw_index),
		.rx_cw_sect(rx_cw_sect), .rx_cw_data(rx_cw_data), .tx_cw_req(tx_cw_req),
		.tx_cw_index(tx_cw_index), .tx_cw_sect(tx_cw_sect), .tx_cw_orig(tx_cw_orig),
		.tx_cw_valid_ff(tx_cw_valid_ff), .tx_cw_data_ff(tx_cw_data_ff),
		.nego_rate_in(nego_rate_in), .line_rate_ff(line_rate_ff));
	always #2.5 mclk = ~mclk;
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task final_report;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge mclk);
		wr_en <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample right there.
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge mclk);
		rd_en <= 1'h0;
		#1;
		chk(rd_data_ff, e, "read data");
	endtask
	task treq(input logic [3:0] s, input logic [31:0] o, input logic [31:0] e);
		@(posedge mclk);
		tx_cw_req <= 1'h1;
		tx_cw_sect <= s;
		tx_cw_orig <= o;
		@(posedge mclk);
		tx_cw_req <= 1'h0;
		#1;
		chk(tx_cw_data_ff, e, "tx word");
		chk({31'h0, tx_cw_valid_ff}, 32'h1, "tx valid");
	endtask
	task t_rx;
		int i, s;
		logic [7:0] x;
		for (i = 0; i < 4; i++)
		begin
			x = 8'(16 + 64 * i);
			for (s = 0; s < 12; s++)
			begin
				@(posedge mclk);
				rx_cw_valid <= 1'h1;
				rx_cw_index <= x;
				rx_cw_sect <= 4'(s);
				rx_cw_data <= {x, 8'(s), 16'hC35A};
			end
			@(posedge mclk);
			rx_cw_valid <= 1'h0;
			for (s = 0; s < 12; s++)
			begin
				wr(`OFS_WORD_SEL, {19'h0, 1'(s), 4'(s >> 1), x});
				rd(`OFS_RX_WORD, {x, 8'(s), 16'hC35A});
			end
		end
	endtask
	task t_tx;
		int s;
		rd(`OFS_LAYER_ONE, 32'h0);
		for (s = 0; s < 6; s++)
		begin
			wr(`OFS_WORD_SEL, {1'h1, 2'h0, 1'(s), 4'(s >> 1), 24'h500000});
			wr(`OFS_TX_WORD, {8'h50, 8'(s), 16'h7E81});
		end
		treq(4'h0, 32'h1234_5678, 32'h1234_5678);
		wr(`OFS_LAYER_ONE, 32'h1);
		for (s = 0; s < 6; s++)
			treq(4'(s), 32'h0, {8'h50, 8'(s), 16'h7E81});
		wr(`OFS_WORD_SEL, 32'h9150_0000);
		wr(`OFS_TX_WORD, 32'hA5A5_A5A5);
		treq(4'h3, 32'h0, 32'hA5A5_A5A5);
		treq(4'h2, 32'h0, 32'h5002_7E81);
		treq(4'hC, 32'h0BAD_0C0C, 32'h0BAD_0C0C);
		wr(`OFS_WORD_SEL, 32'h0050_0000);
		treq(4'h0, 32'hCAFE_0001, 32'hCAFE_0001);
		rd(`OFS_WORD_SEL, 32'h0050_0000);
		treq(4'hC, 32'h0BAD_0C0C, 32'h0BAD_0C0C);
		rd(8'h20, 32'h0);
	endtask
	task t_rate;
		rd(`OFS_LINE_RATE, 32'h0000_0101);
		@(posedge mclk);
		nego_rate_in <= 6'h10;
		repeat (2) @(posedge mclk);
		#1;
		chk({26'h0, line_rate_ff}, 32'h10, "line rate");
		@(posedge mclk);
		nego_rate_in <= 6'h00;
		wr(`OFS_LINE_RATE, 32'h30);
		rd(`OFS_LINE_RATE, 32'h0000_3030);
	endtask
	initial
	begin
		#20000;
		bad_count++;
		final_report();
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'h1;
		t_rx();
		t_tx();
		t_rate();
		final_report();
	end
endmodule
`default_nettype wire
